// ==== include/uadm_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the port
// Assumes inclusion by bare name from the design file
`ifndef UADM_CFG_SVH
`define UADM_CFG_SVH
`define UADM_OFS_RXCHAR    4'h0
`define UADM_OFS_TXCHAR    4'h1
`define UADM_OFS_BAUD      4'h2
`define UADM_OFS_MATCH     4'h3
`define UADM_OFS_CTRL      4'h4
`define UADM_OFS_STAT      4'h5
`define UADM_CTRL_HS       0
`define UADM_CTRL_PW_LO    1
`define UADM_CTRL_ADDRESS_DETECT_ENABLE    3
`define UADM_CTRL_TXEN     4
`define UADM_CTRL_RXEN     5
`define UADM_PW_9BIT       2'h3
`define UADM_RST_BAUD      16'h0000
`define UADM_RST_MATCH     16'h0000
`define UADM_OSR_STD       5'h10
`define UADM_OSR_HS        5'h04
`endif

// ==== include/uadm_pkg.sv ====
// Types shared by the serial port design
// Assumes the cfg header holds all numeric constants
package uadm_pkg;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} uadm_req_type;
	typedef enum logic [3:0] {
		UADM_IDLE  = 4'b0001,
		UADM_START = 4'b0010,
		UADM_DATA  = 4'b0100,
		UADM_STOP  = 4'b1000
	} uadm_state_type;
endpackage : uadm_pkg

// ==== hdl/uadm_top.sv ====
// Serial port data, baud divisor and masked address match
// Assumes a synchronous serial input and a single-cycle register master
//
// Contract
// - Last received character readable, 9 bits
// - Transmit character written through 9-bit field
// - 16-bit divisor, reset zero, sets rate
// - Set mask bits compare reference bits
// - Cleared mask bits are don't care
// - Hardware checks address characters against reference
// - Sixteen or four divisor ticks per bit
// - Ninth bit one marks address character
// - Address detect only in 9-bit mode
`timescale 1ns/1ps
`include "uadm_cfg.svh"
module uadm_top (
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Serial line
	input  wire logic        rx_line,
	output logic             tx_line,
	// Receive event
	output logic             rx_avail
);
	uadm_pkg::uadm_req_type req;
	logic [15:0] baud_divisor_r;
	logic [7:0]  match_mask_r;
	logic [7:0]  match_reference_r;
	logic [5:0]  ctrl_r;
	logic [8:0]  rx_char_r;
	logic [8:0]  tx_hold_r;
	logic        tx_full_r;
	logic [15:0] div_cnt_r;
	logic        tick;
	logic [4:0]  osr;
	logic        nine_bit;
	logic        adr_mode;
	logic        ovf_r;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign nine_bit = (ctrl_r[`UADM_CTRL_PW_LO +: 2] == `UADM_PW_9BIT);
	assign adr_mode = ctrl_r[`UADM_CTRL_ADDRESS_DETECT_ENABLE] & nine_bit;
	assign osr = ctrl_r[`UADM_CTRL_HS] ? `UADM_OSR_HS : `UADM_OSR_STD;
	// Configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			baud_divisor_r    <= `UADM_RST_BAUD;
			match_mask_r      <= 8'h00;
			match_reference_r <= 8'h00;
			ctrl_r            <= 6'h00;
		end else if (req.wr) begin
			case (req.addr)
				`UADM_OFS_BAUD: baud_divisor_r <= req.wdata;
				`UADM_OFS_MATCH: begin
					match_mask_r      <= req.wdata[15:8];
					match_reference_r <= req.wdata[7:0];
				end
				`UADM_OFS_CTRL: ctrl_r <= req.wdata[5:0];
				default: ;
			endcase
		end
	end
	// Divisor tick: one pulse every divisor+1 cycles
	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt_r <= 16'h0000;
			tick      <= 1'b0;
		end else if (div_cnt_r >= baud_divisor_r) begin
			div_cnt_r <= 16'h0000;
			tick      <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
			tick      <= 1'b0;
		end
	end
	// Transmit holding register
	logic tx_take;
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_hold_r <= 9'h000;
			tx_full_r <= 1'b0;
		end else if (req.wr && req.addr == `UADM_OFS_TXCHAR &&
			ctrl_r[`UADM_CTRL_TXEN]) begin
			tx_hold_r <= req.wdata[8:0];
			tx_full_r <= 1'b1;
		end else if (tx_take || !ctrl_r[`UADM_CTRL_TXEN]) begin
			tx_full_r <= 1'b0;
		end
	end
	// Transmitter
	uadm_pkg::uadm_state_type tx_st_r;
	logic [4:0] tx_sub_r;
	logic [3:0] tx_bit_r;
	logic [8:0] tx_sh_r;
	logic [3:0] nbits;
	assign nbits = nine_bit ? 4'h9 : 4'h8;
	assign tx_take = (tx_st_r == uadm_pkg::UADM_IDLE) && tx_full_r;
	always_ff @(posedge clk) begin
		if (rst || !ctrl_r[`UADM_CTRL_TXEN]) begin
			tx_st_r  <= uadm_pkg::UADM_IDLE;
			tx_sub_r <= 5'h00;
			tx_bit_r <= 4'h0;
			tx_sh_r  <= 9'h000;
			tx_line  <= 1'b1;
		end else begin
			case (tx_st_r)
				uadm_pkg::UADM_IDLE: begin
					tx_line <= 1'b1;
					if (tx_full_r) begin
						tx_sh_r  <= tx_hold_r;
						tx_sub_r <= 5'h00;
						tx_st_r  <= uadm_pkg::UADM_START;
					end
				end
				uadm_pkg::UADM_START: begin
					tx_line <= 1'b0;
					if (tick) begin
						if (tx_sub_r == osr - 5'h01) begin
							tx_sub_r <= 5'h00;
							tx_bit_r <= 4'h0;
							tx_st_r  <= uadm_pkg::UADM_DATA;
						end else begin
							tx_sub_r <= tx_sub_r + 5'h01;
						end
					end
				end
				uadm_pkg::UADM_DATA: begin
					tx_line <= tx_sh_r[0];
					if (tick) begin
						if (tx_sub_r == osr - 5'h01) begin
							tx_sub_r <= 5'h00;
							tx_sh_r  <= {1'b0, tx_sh_r[8:1]};
							if (tx_bit_r == nbits - 4'h1) begin
								tx_st_r <= uadm_pkg::UADM_STOP;
							end
							tx_bit_r <= tx_bit_r + 4'h1;
						end else begin
							tx_sub_r <= tx_sub_r + 5'h01;
						end
					end
				end
				uadm_pkg::UADM_STOP: begin
					tx_line <= 1'b1;
					if (tick) begin
						if (tx_sub_r == osr - 5'h01) begin
							tx_sub_r <= 5'h00;
							tx_st_r  <= uadm_pkg::UADM_IDLE;
						end else begin
							tx_sub_r <= tx_sub_r + 5'h01;
						end
					end
				end
				default: tx_st_r <= uadm_pkg::UADM_IDLE;
			endcase
		end
	end
	// Receiver
	uadm_pkg::uadm_state_type rx_st_r;
	logic [4:0] rx_sub_r;
	logic [3:0] rx_bit_r;
	logic [8:0] rx_sh_r;
	logic       rx_done;
	logic [8:0] rx_word;
	assign rx_word = nine_bit ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
	always_ff @(posedge clk) begin
		if (rst || !ctrl_r[`UADM_CTRL_RXEN]) begin
			rx_st_r  <= uadm_pkg::UADM_IDLE;
			rx_sub_r <= 5'h00;
			rx_bit_r <= 4'h0;
			rx_sh_r  <= 9'h000;
			rx_done  <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			case (rx_st_r)
				uadm_pkg::UADM_IDLE: begin
					rx_sub_r <= 5'h00;
					if (!rx_line) begin
						rx_st_r <= uadm_pkg::UADM_START;
					end
				end
				uadm_pkg::UADM_START: begin
					if (tick) begin
						if (rx_sub_r == (osr >> 1) - 5'h01) begin
							rx_sub_r <= 5'h00;
							rx_bit_r <= 4'h0;
							rx_st_r  <= rx_line ? uadm_pkg::UADM_IDLE
								: uadm_pkg::UADM_DATA;
						end else begin
							rx_sub_r <= rx_sub_r + 5'h01;
						end
					end
				end
				uadm_pkg::UADM_DATA: begin
					if (tick) begin
						if (rx_sub_r == osr - 5'h01) begin
							rx_sub_r <= 5'h00;
							rx_sh_r  <= {rx_line, rx_sh_r[8:1]};
							if (rx_bit_r == nbits - 4'h1) begin
								rx_st_r <= uadm_pkg::UADM_STOP;
							end
							rx_bit_r <= rx_bit_r + 4'h1;
						end else begin
							rx_sub_r <= rx_sub_r + 5'h01;
						end
					end
				end
				uadm_pkg::UADM_STOP: begin
					if (tick) begin
						if (rx_sub_r == osr - 5'h01) begin
							rx_sub_r <= 5'h00;
							rx_st_r  <= uadm_pkg::UADM_IDLE;
							rx_done  <= rx_line;
						end else begin
							rx_sub_r <= rx_sub_r + 5'h01;
						end
					end
				end
				default: rx_st_r <= uadm_pkg::UADM_IDLE;
			endcase
		end
	end
	// Address filter
	logic is_addr;
	logic addr_hit;
	logic keep;
	assign is_addr = adr_mode && rx_word[8];
	assign addr_hit = ((rx_word[7:0] ^ match_reference_r) & match_mask_r)
		== 8'h00;
	assign keep = !is_addr || addr_hit;
	// New character wins over a read, an overrun over its clear
	logic rd_rx;
	logic ovf_clr;
	assign rd_rx = req.rd && req.addr == `UADM_OFS_RXCHAR;
	assign ovf_clr = req.wr && req.addr == `UADM_OFS_STAT;
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_char_r <= 9'h000;
			rx_avail  <= 1'b0;
			ovf_r     <= 1'b0;
		end else if (rx_done && keep) begin
			rx_char_r <= rx_word;
			rx_avail  <= 1'b1;
			ovf_r     <= (ovf_r & !ovf_clr) | (rx_avail & !rd_rx);
		end else begin
			if (rd_rx) begin
				rx_avail <= 1'b0;
			end
			if (ovf_clr) begin
				ovf_r <= 1'b0;
			end
		end
	end
	// Read data, one cycle after strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (req.rd) begin
			case (req.addr)
				`UADM_OFS_RXCHAR: reg_rdata <= {7'h00, rx_char_r};
				`UADM_OFS_BAUD:   reg_rdata <= baud_divisor_r;
				`UADM_OFS_MATCH:  reg_rdata <= {match_mask_r, match_reference_r};
				`UADM_OFS_CTRL:   reg_rdata <= {10'h000, ctrl_r};
				`UADM_OFS_STAT:   reg_rdata <= {12'h000, ovf_r, tx_full_r,
					rx_st_r == uadm_pkg::UADM_IDLE, rx_avail};
				default:          reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
	// Checks
	property p_baud_reset;
		@(posedge clk) $fell(rst) |-> baud_divisor_r == 16'h0000;
	endproperty
	a_baud_reset: assert property (p_baud_reset)
		else $error("divisor not zero after reset");
	property p_rx_read;
		@(posedge clk) disable iff (rst)
		req.rd && req.addr == `UADM_OFS_RXCHAR |=>
		reg_rdata == {7'h00, $past(rx_char_r)};
	endproperty
	a_rx_read: assert property (p_rx_read)
		else $error("receive read mismatch");
	property p_drop_miss;
		@(posedge clk) disable iff (rst)
		rx_done && adr_mode && rx_word[8] && !addr_hit |=> $stable(rx_char_r);
	endproperty
	a_drop_miss: assert property (p_drop_miss)
		else $error("unmatched address kept");
	property p_keep_hit;
		@(posedge clk) disable iff (rst)
		rx_done && adr_mode && rx_word[8] && addr_hit |=> rx_avail;
	endproperty
	a_keep_hit: assert property (p_keep_hit)
		else $error("matched address dropped");
	property p_no_adr_8bit;
		@(posedge clk) disable iff (rst)
		rx_done && !nine_bit |=> rx_avail;
	endproperty
	a_no_adr_8bit: assert property (p_no_adr_8bit)
		else $error("filter active outside 9-bit mode");
	property p_mask_zero;
		@(posedge clk) disable iff (rst) match_mask_r == 8'h00 |-> addr_hit;
	endproperty
	a_mask_zero: assert property (p_mask_zero)
		else $error("cleared mask still compared");
	property p_mask_full;
		@(posedge clk) disable iff (rst)
		match_mask_r == 8'hff |-> addr_hit == (rx_word[7:0] == match_reference_r);
	endproperty
	a_mask_full: assert property (p_mask_full)
		else $error("set mask not compared");
	property p_osr;
		@(posedge clk) disable iff (rst)
		tx_st_r != uadm_pkg::UADM_IDLE |-> tx_sub_r <
			(ctrl_r[`UADM_CTRL_HS] ? `UADM_OSR_HS : `UADM_OSR_STD);
	endproperty
	a_osr: assert property (p_osr)
		else $error("wrong ticks per bit");
	property p_tx_load;
		@(posedge clk) disable iff (rst)
		req.wr && req.addr == `UADM_OFS_TXCHAR && ctrl_r[`UADM_CTRL_TXEN]
		|=> tx_hold_r == $past(req.wdata[8:0]) && tx_full_r;
	endproperty
	a_tx_load: assert property (p_tx_load)
		else $error("transmit write lost");
	property p_addr_flag;
		@(posedge clk) disable iff (rst)
		rx_done && adr_mode && !rx_word[8] |=>
		rx_avail && rx_char_r == $past(rx_word);
	endproperty
	a_addr_flag: assert property (p_addr_flag)
		else $error("data character taken as address");
endmodule : uadm_top

// ==== tb/uadm_remote.sv ====
// Remote serial device: sends frames to the port, captures its frames
// Assumes a line idle high, LSB first, one stop bit, no parity
`timescale 1ns/1ps
module uadm_remote (
	// Clock
	input  wire logic clk,
	// Serial lines
	output logic      to_dev,
	input  wire logic from_dev
);
	initial to_dev = 1'b1;

	// Start bit, n data bits, stop bit, each bclk clocks long
	task automatic send(input logic [8:0] ch, input int n, input int bclk);
		@(posedge clk);
		to_dev <= 1'b0;
		repeat (bclk) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			to_dev <= ch[i];
			repeat (bclk) @(posedge clk);
		end
		to_dev <= 1'b1;
		repeat (bclk) @(posedge clk);
	endtask : send

	// Waits for a start bit, then samples each data bit mid-bit
	task automatic recv(output logic [8:0] ch, input int n, input int bclk);
		int w;
		ch = 9'h000;
		w = 0;
		while (from_dev !== 1'b0 && w < 4000) begin
			@(posedge clk);
			w++;
		end
		repeat (bclk / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (bclk) @(posedge clk);
			ch[i] = from_dev;
		end
		repeat (bclk) @(posedge clk);
	endtask : recv
endmodule : uadm_remote

// ==== tb/uadm_top_tb.sv ====
// Register and serial tests for the serial port
// Assumes the remote model on the serial lines
`timescale 1ns/1ps
`include "uadm_cfg.svh"
module uadm_top_tb;
	logic        clk;
	logic        rst;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        rx_line;
	logic        tx_line;
	logic        rx_avail;
	int          errors;
	int          checks_done;

	localparam logic [15:0] DIV = 16'h0001;
	localparam logic [15:0] CT [6] = '{16'h0030, 16'h003f, 16'h003f,
		16'h003f, 16'h0037, 16'h0039};
	localparam logic [8:0] CH [6] = '{9'h05a, 9'h13a, 9'h14a,
		9'h04a, 9'h14a, 9'h0c5};
	localparam logic KP [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

	uadm_top uadm_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_line(rx_line), .tx_line(tx_line),
		.rx_avail(rx_avail));
	uadm_remote uadm_remote_i (.clk(clk), .to_dev(rx_line),
		.from_dev(tx_line));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data stand in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	initial begin
		#400000;
		errors++;
		end_of_test();
	end

	initial begin
		logic [15:0] d;
		logic [8:0]  got;
		logic [8:0]  last;
		int          n;
		int          b;
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		errors = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(`UADM_OFS_BAUD, d);
		chk(d, `UADM_RST_BAUD);
		chk({15'h0, tx_line}, 16'h0001);
		rd(`UADM_OFS_MATCH, d);
		chk(d, `UADM_RST_MATCH);
		rd(`UADM_OFS_RXCHAR, d);
		chk(d, 16'h0000);
		rd(4'hf, d);
		chk(d, 16'h0000);
		wr(`UADM_OFS_BAUD, 16'ha5c3);
		rd(`UADM_OFS_BAUD, d);
		chk(d, 16'ha5c3);
		wr(`UADM_OFS_RXCHAR, 16'h01ff);
		rd(`UADM_OFS_RXCHAR, d);
		chk(d, 16'h0000);
		wr(`UADM_OFS_BAUD, DIV);
		wr(`UADM_OFS_MATCH, 16'hf030);
		rd(`UADM_OFS_MATCH, d);
		chk(d, 16'hf030);
		wr(`UADM_OFS_CTRL, 16'h003f);
		b = (DIV + 1) * `UADM_OSR_HS;
		fork
			uadm_remote_i.recv(got, 9, b);
			wr(`UADM_OFS_TXCHAR, 16'hfda5);
		join
		chk({7'h0, got}, 16'h01a5);
		rd(`UADM_OFS_TXCHAR, d);
		chk(d, 16'h0000);
		rd(`UADM_OFS_CTRL, d);
		chk(d, 16'h003f);
		rd(`UADM_OFS_STAT, d);
		chk(d, 16'h0002);
		for (int k = 0; k < 6; k++) begin
			wr(`UADM_OFS_CTRL, CT[k]);
			n = (CT[k][2:1] == `UADM_PW_9BIT) ? 9 : 8;
			b = (DIV + 1) * (CT[k][0] ? `UADM_OSR_HS : `UADM_OSR_STD);
			uadm_remote_i.send(CH[k], n, b);
			#1;
			chk({15'h0, rx_avail}, {15'h0, KP[k]});
			rd(`UADM_OFS_RXCHAR, d);
			if (KP[k])
				last = CH[k];
			chk(d, {7'h0, last});
		end
		end_of_test();
	end
endmodule : uadm_top_tb
